// ### design/uart_enhanced_feature_control.sv
/*
 * Enhanced-feature logic of one UART channel: half-duplex direction
 * control with turnaround delay, scratch register, trigger table and
 * hysteresis, IR receive polarity, software flow timing, write gate of
 * the protected enhanced bits, and an event interrupt.
 * Assumes the core gives one bit_tick per programmed bit time (prescaler
 * included), tx_load when a byte enters the transmitter, and FIFO levels
 * on the same clock. The IR receive pin is asynchronous.
 */
// Implementation choices: the placing of the registers and the Wishbone slave port.
module uart_enhanced_feature_control
  import uart_efc_pkg::*;
#(
  parameter int unsigned CHAR_BITS = CHAR_BITS_DEF
) (
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                soft_rst_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [WB_DAT_W-1:0] wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic [WB_DAT_W-1:0]      wb_dat_o,
  output logic                     wb_ack_o,
  input  wire tx_status_t          core_i,
  input  wire rx_levels_t          lvl_i,
  input  wire logic                ir_rx_pin_i,
  output logic                     ir_rx_data_o,
  output logic                     rts_dir_o,
  output logic                     tx_int_o,
  output logic                     flow_stop_o,
  output logic                     xoff_send_o,
  output logic                     xon_send_o,
  output logic [3:0]               sw_flow_sel_o,
  output logic [1:0]               trig_table_o,
  output enh_bits_t                enh_o,
  output logic                     irq_o
);

  localparam logic [7:0] XOFF_BITS = 8'(XOFF_CHARS * CHAR_BITS);

  // ==========================================================
  // Registers
  logic                ack_ff;
  logic [WB_DAT_W-1:0] dat_ff;
  logic [3:0]          turn_ff;
  logic [7:0]          scratch_ff;
  logic [7:0]          feature_ff;
  logic [7:0]          enh_ff;
  enh_bits_t           prot_ff;
  logic [EV_W-1:0]     evt_ff;
  logic [EV_W-1:0]     mask_ff;
  rs485_state_t        state_ff;
  rs485_state_t        nxt_state;
  logic [3:0]          tcnt_ff;
  logic                flow_stop_ff;
  logic                xoff_sent_ff;
  logic [7:0]          xcnt_ff;
  logic                xoff_ff;
  logic                xon_ff;
  logic                ir_meta_ff;
  logic                ir_sync_ff;
  logic                ir_ff;
  logic                txint_prev_ff;
  logic                turn_done;

  // ==========================================================
  // Bus slave
  logic req;
  logic wr;
  logic enh_en;
  logic clr;

  assign req    = wb_cyc_i & wb_stb_i;
  assign wr     = req & ack_ff & wb_we_i & wb_sel_i[0];
  assign enh_en = enh_ff[EF_ENH];
  assign clr    = soft_rst_i;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (wb_adr_i)
      ADR_SCRATCH: rd_byte = scratch_ff;
      ADR_FEATURE: rd_byte = feature_ff;
      ADR_ENH:     rd_byte = enh_ff;
      ADR_IEN:     rd_byte = {prot_ff.ien_hi, 4'h0};
      ADR_IST:     rd_byte = {2'h0, prot_ff.ist_hi, 4'h0};
      ADR_FIFO:    rd_byte = {2'h0, prot_ff.fifo_hi, 4'h0};
      ADR_MDM:     rd_byte = {prot_ff.mdm_hi, 5'h00};
      ADR_EVT:     rd_byte = {4'h0, evt_ff};
      ADR_MASK:    rd_byte = {4'h0, mask_ff};
      ADR_STATE:   rd_byte = {3'h0, flow_stop_ff, xoff_sent_ff,
                              1'b0, state_ff};
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req & ~ack_ff) begin
      dat_ff <= {24'h00_0000, rd_byte};
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ==========================================================
  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scratch_ff <= SCRATCH_RST;
    end else if (clr) begin
      scratch_ff <= SCRATCH_RST;
    end else if (wr && wb_adr_i == ADR_SCRATCH) begin
      scratch_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      feature_ff <= FEATURE_RST;
    end else if (clr) begin
      feature_ff <= FEATURE_RST;
    end else if (wr && wb_adr_i == ADR_FEATURE) begin
      feature_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enh_ff <= ENH_RST;
    end else if (clr) begin
      enh_ff <= ENH_RST;
    end else if (wr && wb_adr_i == ADR_ENH) begin
      enh_ff <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      turn_ff <= TURN_RST;
    end else if (clr) begin
      turn_ff <= TURN_RST;
    end else if (wr && wb_adr_i == ADR_TURN && enh_en) begin
      turn_ff <= wb_dat_i[TURN_LSB +: 4];
    end
  end

  // Protected bits hold their value while the enable is clear, unless soft reset clears them
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prot_ff <= '0;
    end else if (clr) begin
      prot_ff <= '0;
    end else if (wr && enh_en) begin
      unique case (wb_adr_i)
        ADR_IEN:  prot_ff.ien_hi  <= wb_dat_i[IEN_ENH_LSB +: 4];
        ADR_IST:  prot_ff.ist_hi  <= wb_dat_i[IST_ENH_LSB +: 2];
        ADR_FIFO: prot_ff.fifo_hi <= wb_dat_i[FIFO_ENH_LSB +: 2];
        ADR_MDM:  prot_ff.mdm_hi  <= wb_dat_i[MDM_ENH_LSB +: 3];
        default: prot_ff <= prot_ff;
      endcase
    end
  end

  assign enh_o         = prot_ff;
  assign sw_flow_sel_o = enh_ff[EF_SWFC_LSB +: 4];
  assign trig_table_o  = feature_ff[FC_TABLE_LSB +: 2];

  // ==========================================================
  // Half-duplex direction control
  logic rs485_en;
  logic tx_done;
  assign rs485_en = feature_ff[FC_RS485];
  assign tx_done  = core_i.hold_empty & core_i.sreg_empty;

  always_comb begin
    nxt_state = state_ff;
    turn_done = 1'b0;
    if (!rs485_en) begin
      nxt_state = RX_IDLE;
    end else if (core_i.tx_load) begin
      nxt_state = TX_ACTIVE;
    end else begin
      unique case (state_ff)
        RX_IDLE: nxt_state = RX_IDLE;
        TX_ACTIVE: begin
          if (tx_done) begin
            if (turn_ff == 4'h0) begin
              nxt_state = RX_IDLE;
              turn_done = 1'b1;
            end else begin
              nxt_state = TURNAROUND;
            end
          end
        end
        TURNAROUND: begin
          if (core_i.bit_tick && tcnt_ff == turn_ff - 4'h1) begin
            nxt_state = RX_IDLE;
            turn_done = 1'b1;
          end
        end
        default: nxt_state = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= RX_IDLE;
    end else if (clr) begin
      state_ff <= RX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit-time counter of the turnaround delay
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tcnt_ff <= 4'h0;
    end else if (clr || state_ff != TURNAROUND) begin
      tcnt_ff <= 4'h0;
    end else if (core_i.bit_tick) begin
      tcnt_ff <= tcnt_ff + 4'h1;
    end
  end

  assign rts_dir_o = rs485_en && state_ff != RX_IDLE;
  assign tx_int_o  = rs485_en ? core_i.sreg_empty
                              : core_i.hold_empty;

  // ==========================================================
  // Flow-control thresholds
  logic [LVL_W-1:0] hyst;
  logic             use_hyst;
  logic [LVL_W-1:0] upper;
  logic [LVL_W-1:0] lower;

  always_comb begin
    hyst     = hyst_chars(feature_ff[FC_HYST_LSB +: 4]);
    use_hyst = trig_table_o == TABLE_D && hyst != 7'h00;
    if (use_hyst) begin
      upper = LVL_W'(lvl_i.trig + hyst);
      lower = (lvl_i.trig > hyst) ? LVL_W'(lvl_i.trig - hyst) : 7'h00;
    end else begin
      upper = lvl_i.next_up;
      lower = lvl_i.next_dn;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flow_stop_ff <= 1'b0;
    end else if (clr) begin
      flow_stop_ff <= 1'b0;
    end else if (lvl_i.level >= upper) begin
      flow_stop_ff <= 1'b1;
    end else if (lvl_i.level < lower) begin
      flow_stop_ff <= 1'b0;
    end
  end

  assign flow_stop_o = flow_stop_ff;

  // ==========================================================
  // Software flow: Xoff after two characters, Xon below lower level
  logic swfc_tx;
  assign swfc_tx = enh_ff[EF_SWFC_LSB + 2] | enh_ff[EF_SWFC_LSB + 3];

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xoff_sent_ff <= 1'b0;
      xcnt_ff      <= 8'h00;
      xoff_ff      <= 1'b0;
      xon_ff       <= 1'b0;
    end else if (clr || !swfc_tx) begin
      xoff_sent_ff <= 1'b0;
      xcnt_ff      <= 8'h00;
      xoff_ff      <= 1'b0;
      xon_ff       <= 1'b0;
    end else begin
      xoff_ff <= 1'b0;
      xon_ff  <= 1'b0;
      if (!xoff_sent_ff) begin
        if (lvl_i.level < lvl_i.trig) begin
          xcnt_ff <= 8'h00;
        end else if (core_i.bit_tick) begin
          if (xcnt_ff == XOFF_BITS - 8'h01) begin
            xcnt_ff      <= 8'h00;
            xoff_ff      <= 1'b1;
            xoff_sent_ff <= 1'b1;
          end else begin
            xcnt_ff <= xcnt_ff + 8'h01;
          end
        end
      end else if (lvl_i.level < lower) begin
        xon_ff       <= 1'b1;
        xoff_sent_ff <= 1'b0;
      end
    end
  end

  assign xoff_send_o = xoff_ff;
  assign xon_send_o  = xon_ff;

  // ==========================================================
  // Infrared receive polarity
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ir_meta_ff <= 1'b0;
      ir_sync_ff <= 1'b0;
      ir_ff      <= 1'b0;
    end else begin
      ir_meta_ff <= ir_rx_pin_i;
      ir_sync_ff <= ir_meta_ff;
      ir_ff      <= ir_sync_ff ^ feature_ff[FC_IR_INV];
    end
  end

  assign ir_rx_data_o = ir_ff;

  // ==========================================================
  // Event interrupt: sticky, write one to clear, set wins
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  always_comb begin
    ev_set           = '0;
    ev_set[EV_TXINT] = tx_int_o & ~txint_prev_ff;
    ev_set[EV_XOFF]  = xoff_ff;
    ev_set[EV_XON]   = xon_ff;
    ev_set[EV_TURN]  = turn_done;
    ev_clr = (wr && wb_adr_i == ADR_EVT) ? wb_dat_i[EV_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txint_prev_ff <= 1'b1; // Idle interrupt level
      evt_ff        <= EV_RST;
    end else if (clr) begin
      txint_prev_ff <= 1'b1; // Idle interrupt level
      evt_ff        <= EV_RST;
    end else begin
      txint_prev_ff <= tx_int_o;
      evt_ff        <= (evt_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_ff <= EV_RST;
    end else if (clr) begin
      mask_ff <= EV_RST;
    end else if (wr && wb_adr_i == ADR_MASK) begin
      mask_ff <= wb_dat_i[EV_W-1:0];
    end
  end

  assign irq_o = |(evt_ff & mask_ff);

endmodule : uart_enhanced_feature_control

// ### shared/uart_efc_pkg.sv
/*
 * Constants, carriers and lookup for the per-channel enhanced-feature
 * block of a UART: register map, field layout, reset values, timing.
 * Assumes a 32-bit classic Wishbone register bus and 7-bit FIFO levels.
 */
package uart_efc_pkg;

  // ==========================================================
  // Bus and widths
  localparam int unsigned WB_ADR_W = 8;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned LVL_W    = 7;
  localparam int unsigned EV_W     = 4;

  // ==========================================================
  // Register byte addresses
  localparam logic [WB_ADR_W-1:0] ADR_TURN    = 8'h00;
  localparam logic [WB_ADR_W-1:0] ADR_SCRATCH = 8'h04;
  localparam logic [WB_ADR_W-1:0] ADR_FEATURE = 8'h08;
  localparam logic [WB_ADR_W-1:0] ADR_ENH     = 8'h0C;
  localparam logic [WB_ADR_W-1:0] ADR_IEN     = 8'h10;
  localparam logic [WB_ADR_W-1:0] ADR_IST     = 8'h14;
  localparam logic [WB_ADR_W-1:0] ADR_FIFO    = 8'h18;
  localparam logic [WB_ADR_W-1:0] ADR_MDM     = 8'h1C;
  localparam logic [WB_ADR_W-1:0] ADR_EVT     = 8'h20;
  localparam logic [WB_ADR_W-1:0] ADR_MASK    = 8'h24;
  localparam logic [WB_ADR_W-1:0] ADR_STATE   = 8'h28;

  // ==========================================================
  // Reset values
  localparam logic [7:0]      SCRATCH_RST = 8'hFF;
  localparam logic [7:0]      FEATURE_RST = 8'h00;
  localparam logic [7:0]      ENH_RST     = 8'h00;
  localparam logic [3:0]      TURN_RST    = 4'h0;
  localparam logic [EV_W-1:0] EV_RST      = 4'h0;

  // ==========================================================
  // Field positions
  localparam int unsigned FC_HYST_LSB  = 0;
  localparam int unsigned FC_IR_INV    = 4;
  localparam int unsigned FC_RS485     = 5;
  localparam int unsigned FC_TABLE_LSB = 6;
  localparam int unsigned EF_SWFC_LSB  = 0;
  localparam int unsigned EF_ENH       = 4;
  localparam int unsigned TURN_LSB     = 4;
  localparam int unsigned IEN_ENH_LSB  = 4;
  localparam int unsigned IST_ENH_LSB  = 4;
  localparam int unsigned FIFO_ENH_LSB = 4;
  localparam int unsigned MDM_ENH_LSB  = 5;
  localparam logic [1:0]  TABLE_D      = 2'h3;

  // Event bits
  localparam int unsigned EV_TXINT = 0;
  localparam int unsigned EV_XOFF  = 1;
  localparam int unsigned EV_XON   = 2;
  localparam int unsigned EV_TURN  = 3;

  // ==========================================================
  // Timing
  localparam int unsigned CHAR_BITS_DEF = 10;
  localparam int unsigned XOFF_CHARS    = 2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic bit_tick;
    logic tx_load;
    logic hold_empty;
    logic sreg_empty;
  } tx_status_t;

  typedef struct packed {
    logic [LVL_W-1:0] level;
    logic [LVL_W-1:0] trig;
    logic [LVL_W-1:0] next_up;
    logic [LVL_W-1:0] next_dn;
  } rx_levels_t;

  typedef struct packed {
    logic [3:0] ien_hi;
    logic [1:0] ist_hi;
    logic [1:0] fifo_hi;
    logic [2:0] mdm_hi;
  } enh_bits_t;

  typedef enum logic [1:0] {
    RX_IDLE    = 2'h0,
    TX_ACTIVE  = 2'h1,
    TURNAROUND = 2'h3
  } rs485_state_t;

  // Hysteresis code to characters
  function automatic logic [LVL_W-1:0] hyst_chars(input logic [3:0] code);
    logic [LVL_W-1:0] r;
    unique case (code)
      4'h0: r = 7'h00;
      4'h1: r = 7'h04;
      4'h2: r = 7'h06;
      4'h3: r = 7'h08;
      4'h4: r = 7'h08;
      4'h5: r = 7'h10;
      4'h6: r = 7'h18;
      4'h7: r = 7'h20;
      4'h8: r = 7'h28;
      4'h9: r = 7'h2C;
      4'hA: r = 7'h30;
      4'hB: r = 7'h34;
      4'hC: r = 7'h0C;
      4'hD: r = 7'h14;
      4'hE: r = 7'h1C;
      4'hF: r = 7'h24;
    endcase
    return r;
  endfunction : hyst_chars

endpackage : uart_efc_pkg

// ### verification/tx_core_model.sv
/*
 * Model of the UART transmitter core beside the block: bit timing and
 * one frame of BITS bit times per send request.
 * Assumes send_i is a one-cycle pulse issued only while idle.
 */
module tx_core_model
  import uart_efc_pkg::*;
#(
  parameter int unsigned DIV  = 4,
  parameter int unsigned BITS = 10
) (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  input  wire logic send_i,
  output tx_status_t core_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div_ff;
  logic [4:0] left_ff;
  logic       tick_ff;
  logic       load_ff;
  logic       hold_ff;
  logic       sreg_ff;

  assign core_o = '{bit_tick: tick_ff, tx_load: load_ff,
                    hold_empty: hold_ff, sreg_empty: sreg_ff};

  // One tick per programmed bit period
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : bit_timer
    if (!nrst_i) begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= (div_ff == 8'(DIV - 1)) ? 8'h00 : div_ff + 8'h01;
      tick_ff <= (div_ff == 8'(DIV - 1));
    end
  end

  // Holding register empties at once; shifter idle after the stop bit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : shifter
    if (!nrst_i) begin
      left_ff <= 5'h00;
      load_ff <= 1'b0;
      hold_ff <= 1'b1;
      sreg_ff <= 1'b1;
    end else begin
      load_ff <= send_i;
      hold_ff <= !send_i;
      if (send_i) begin
        left_ff <= 5'(BITS);
        sreg_ff <= 1'b0;
      end else if (left_ff != 5'h00 && tick_ff) begin
        left_ff <= left_ff - 5'h01;
        if (left_ff == 5'h01) sreg_ff <= 1'b1;
      end
    end
  end
endmodule : tx_core_model

// ### verification/uart_efc_sva.sv
/*
 * Checker for the enhanced-feature block: bus answer, direction control,
 * interrupt source, IR polarity, flow timing and protected bits.
 * Assumes it sees only the block's top-level ports; bound below.
 */
module uart_efc_sva
  import uart_efc_pkg::*;
(
  input wire logic                sys_clk_i,
  input wire logic                nrst_i,
  input wire logic                soft_rst_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic                wb_we_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire tx_status_t          core_i,
  input wire logic                ir_rx_pin_i,
  input wire logic                ir_rx_data_o,
  input wire logic                rts_dir_o,
  input wire logic                tx_int_o,
  input wire logic                xoff_send_o,
  input wire logic [3:0]          sw_flow_sel_o,
  input wire logic [1:0]          trig_table_o,
  input wire enh_bits_t           enh_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Shadow of the written registers
  logic [7:0] fc_ff;
  logic [7:0] ef_ff;
  logic [3:0] turn_ff;
  logic [4:0] tick_cnt_ff;
  logic       wr_hit;

  assign wr_hit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : shadow
    if (!nrst_i || soft_rst_i) begin
      fc_ff   <= 8'h00;
      ef_ff   <= 8'h00;
      turn_ff <= 4'h0;
    end else if (wr_hit) begin
      if (wb_adr_i == ADR_FEATURE) fc_ff <= wb_dat_i[7:0];
      if (wb_adr_i == ADR_ENH) ef_ff <= wb_dat_i[7:0];
      if (wb_adr_i == ADR_TURN && ef_ff[EF_ENH]) turn_ff <= wb_dat_i[7:4];
    end
  end

  // Bit times counted while idle transmitter keeps direction high
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin : turn_ticks
    if (!nrst_i) tick_cnt_ff <= 5'h00;
    else if (core_i.tx_load) tick_cnt_ff <= 5'h00;
    else if (rts_dir_o && core_i.hold_empty && core_i.sreg_empty &&
             core_i.bit_tick) tick_cnt_ff <= tick_cnt_ff + 5'h01;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_ack_pulse: assert property (s_req |=> s_ack)
    else $error("bus answer is not a one-cycle ack");
  chk_txint_src: assert property (
    tx_int_o == (fc_ff[FC_RS485] ? core_i.sreg_empty : core_i.hold_empty))
    else $error("transmit interrupt from wrong source");
  chk_rts_load: assert property (
    fc_ff[FC_RS485] && core_i.tx_load |=> rts_dir_o)
    else $error("direction not raised on byte load");
  chk_rts_rise: assert property (
    fc_ff[FC_RS485] && $rose(rts_dir_o) |-> $past(core_i.tx_load))
    else $error("direction raised without a load");
  chk_turn_count: assert property (
    fc_ff[FC_RS485] && $fell(rts_dir_o) |-> tick_cnt_ff == {1'b0, turn_ff})
    else $error("turnaround delay count wrong");
  chk_ir_polarity: assert property (
    $past(fc_ff[FC_IR_INV], 4) == fc_ff[FC_IR_INV] |->
      ir_rx_data_o == ($past(ir_rx_pin_i, 3) ^ fc_ff[FC_IR_INV]))
    else $error("IR receive polarity wrong");
  chk_xoff_tick: assert property (
    $rose(xoff_send_o) |-> $past(core_i.bit_tick))
    else $error("xoff not aligned to a bit time");
  chk_enh_gate: assert property (
    !ef_ff[EF_ENH] && !soft_rst_i |=> $stable(enh_o))
    else $error("protected bits changed while locked");
  chk_soft_clear: assert property (
    soft_rst_i |=> enh_o == '0 && !rts_dir_o)
    else $error("protected bits not cleared by reset");
  chk_flow_sel: assert property (
    sw_flow_sel_o == ef_ff[3:0] && trig_table_o == fc_ff[7:6])
    else $error("flow or table select does not follow register");
endmodule : uart_efc_sva

bind uart_enhanced_feature_control uart_efc_sva u_uart_efc_sva (
  .sys_clk_i, .nrst_i, .soft_rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_i, .ir_rx_pin_i,
  .ir_rx_data_o, .rts_dir_o, .tx_int_o, .xoff_send_o, .sw_flow_sel_o,
  .trig_table_o, .enh_o);

// ### verification/uart_enhanced_feature_control_test.sv
/*
 * Self-checking bench of the enhanced-feature block: register table,
 * direction control, hysteresis, flow timing, interrupt, IR, reset.
 * Assumes the checker is bound to the design and the core model drives
 * the transmitter status.
 */
module uart_enhanced_feature_control_test
  import uart_efc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned CB = 4;
  typedef struct { logic [7:0] a, d, e; } row_t;

  logic sys_clk_i = 1'b0;
  logic nrst_i, soft_rst_i, wb_we_i, wb_cyc_i, wb_stb_i, ir_rx_pin_i;
  logic send_req, wb_ack_o, ir_rx_data_o, rts_dir_o, tx_int_o, irq_o;
  logic flow_stop_o, xoff_send_o, xon_send_o;
  logic [WB_ADR_W-1:0] wb_adr_i;
  logic [WB_DAT_W-1:0] wb_dat_i, wb_dat_o;
  logic [3:0]          wb_sel_i, sw_flow_sel_o;
  logic [1:0]          trig_table_o;
  logic [7:0]          rd;
  tx_status_t          core_i;
  rx_levels_t          lvl_i;
  enh_bits_t           enh_o;
  int                  error_cnt = 0;
  int                  n_checks = 0;
  int                  n, k, up, lo;
  int hyst [17] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52,
                    12, 20, 28, 36, 0};
  logic [3:0] dly [3] = '{4'h0, 4'h3, 4'hF};
  row_t rows [9] = '{'{ADR_ENH, 8'h10, 8'h10}, '{ADR_SCRATCH, 8'h5A, 8'h5A},
    '{ADR_TURN, 8'h30, 8'h00}, '{ADR_FEATURE, 8'hE0, 8'hE0},
    '{ADR_IEN, 8'hF0, 8'hF0}, '{ADR_MDM, 8'hE0, 8'hE0},
    '{ADR_IST, 8'h30, 8'h30}, '{ADR_FIFO, 8'h30, 8'h30},
    '{8'h3C, 8'h77, 8'h00}};
  row_t rst_rows [5] = '{'{ADR_SCRATCH, 8'h00, 8'hFF},
    '{ADR_FEATURE, 8'h00, 8'h00}, '{ADR_IEN, 8'h00, 8'h00},
    '{ADR_MDM, 8'h00, 8'h00}, '{ADR_EVT, 8'h00, 8'h00}};

  always #12.5 sys_clk_i = ~sys_clk_i;

  uart_enhanced_feature_control #(.CHAR_BITS(CB))
    u_uart_enhanced_feature_control (.sys_clk_i, .nrst_i, .soft_rst_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .core_i, .lvl_i, .ir_rx_pin_i, .ir_rx_data_o,
    .rts_dir_o, .tx_int_o, .flow_stop_o, .xoff_send_o, .xon_send_o,
    .sw_flow_sel_o, .trig_table_o, .enh_o, .irq_o);
  tx_core_model #(.DIV(4), .BITS(10)) u_tx_core_model (.sys_clk_i,
    .nrst_i, .send_i(send_req), .core_o(core_i));

  // ==========================================================
  // Tasks
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask : cmp8

  task automatic cmp1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask : cmp1

  task automatic wb(input logic [7:0] a, input logic [7:0] d,
                    input logic we);
    int t;
    t = 0;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1 && t++ < 20);
    cmp1(wb_ack_o, 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wb

  task automatic xfer(input logic [3:0] d);
    logic [4:0] c;
    int w;
    c = 5'h00;
    w = 0;
    send_req <= 1'b1;
    @(posedge sys_clk_i);
    send_req <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    cmp1(rts_dir_o, 1'b1);
    cmp1(tx_int_o, 1'b0);
    wb(ADR_STATE, 8'h00, 1'b0);
    cmp8(rd, 8'h01);
    while (rts_dir_o === 1'b1 && w++ < 400) begin
      @(negedge sys_clk_i);
      if (core_i.bit_tick && core_i.hold_empty && core_i.sreg_empty) c++;
    end
    cmp8({3'h0, c}, {4'h0, d});
    @(posedge sys_clk_i);
  endtask : xfer

  task automatic lv(input int l, input logic e);
    lvl_i.level <= l[6:0];
    repeat (3) @(posedge sys_clk_i);
    cmp1(flow_stop_o, e);
  endtask : lv

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // ==========================================================
  // Sequence
  initial begin : watchdog
    #200us;
    error_cnt++;
    complete_run();
  end

  initial begin : main
    nrst_i = 1'b0;
    soft_rst_i = 1'b0;
    {wb_we_i, wb_cyc_i, wb_stb_i, ir_rx_pin_i, send_req} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    lvl_i = '{level: 7'h00, trig: 7'h3C, next_up: 7'h40, next_dn: 7'h10};
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    foreach (rows[i]) begin
      wb(rows[i].a, rows[i].d, 1'b1);
      wb(rows[i].a, 8'h00, 1'b0);
      cmp8(rd, rows[i].e);
    end
    $display("test register table done");
    wb(ADR_FEATURE, 8'h20, 1'b1);
    foreach (dly[i]) begin
      wb(ADR_TURN, {dly[i], 4'h0}, 1'b1);
      xfer(dly[i]);
    end
    wb(ADR_ENH, 8'h00, 1'b1);
    wb(ADR_TURN, 8'h00, 1'b1);
    wb(ADR_ENH, 8'h10, 1'b1);
    xfer(4'hF);
    wb(ADR_FEATURE, 8'h00, 1'b1);
    send_req <= 1'b1;
    @(posedge sys_clk_i);
    send_req <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cmp1(tx_int_o, 1'b1);
    cmp1(rts_dir_o, 1'b0);
    $display("test direction control done");
    foreach (hyst[c]) begin
      wb(ADR_FEATURE, c < 16 ? {4'hC, c[3:0]} : 8'h05, 1'b1);
      up = hyst[c] != 0 ? 60 + hyst[c] : 64;
      lo = hyst[c] != 0 ? 60 - hyst[c] : 16;
      lv(up - 1, 1'b0);
      lv(up, 1'b1);
      lv(lo, 1'b1);
      lv(lo - 1, 1'b0);
    end
    $display("test hysteresis done");
    wb(ADR_EVT, 8'hFF, 1'b1);
    wb(ADR_ENH, 8'h00, 1'b1);
    wb(ADR_ENH, 8'h18, 1'b1);
    @(negedge sys_clk_i iff core_i.bit_tick === 1'b1);
    @(posedge sys_clk_i);
    lvl_i.level <= 7'h3C;
    n = 0;
    k = 0;
    while (xoff_send_o !== 1'b1 && k++ < 200) begin
      @(negedge sys_clk_i);
      if (core_i.bit_tick === 1'b1) n++;
    end
    cmp8(n[7:0], 8'(2 * CB));
    @(posedge sys_clk_i);
    lvl_i.level <= 7'h0F;
    k = 0;
    while (xon_send_o !== 1'b1 && k++ < 8) @(negedge sys_clk_i);
    cmp1(xon_send_o, 1'b1);
    @(posedge sys_clk_i);
    wb(ADR_EVT, 8'h00, 1'b0);
    cmp8(rd, 8'h06);
    cmp1(irq_o, 1'b0);
    wb(ADR_MASK, 8'h04, 1'b1);
    cmp1(irq_o, 1'b1);
    wb(ADR_EVT, 8'h04, 1'b1);
    cmp1(irq_o, 1'b0);
    $display("test flow and interrupt done");
    for (int v = 0; v < 2; v++) begin
      wb(ADR_FEATURE, {3'h0, v[0], 4'h0}, 1'b1);
      ir_rx_pin_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      cmp1(ir_rx_data_o, ~v[0]);
      ir_rx_pin_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      cmp1(ir_rx_data_o, v[0]);
    end
    $display("test infrared done");
    wb(ADR_ENH, 8'h00, 1'b1);
    wb(ADR_IEN, 8'h00, 1'b1);
    wb(ADR_IEN, 8'h00, 1'b0);
    cmp8(rd, 8'hF0);
    soft_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    soft_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    foreach (rst_rows[i]) begin
      wb(rst_rows[i].a, 8'h00, 1'b0);
      cmp8(rd, rst_rows[i].e);
    end
    cmp1(enh_o === '0, 1'b1);
    $display("test reset done");
    complete_run();
  end
endmodule : uart_enhanced_feature_control_test
